// *** rtl/bscu_top.sv ***
// Branch, skip and indirect call unit with an APB register slave.
// Assumes one core clock; instruction inputs come from same-clock logic.
// Operation
// - Extended indirect call loads Z into PC low, high register into top, 3 cycles.
// - Indirect call loads Z into PC low, zeroes top bits, 2 or 3 cycles.
// - Compare-skip skips next instruction when both registers equal, 1/2/3 cycles.
// - Register bit-clear skip skips when selected register bit is 0.
// - Register bit-set skip skips when selected register bit is 1.
// - I/O bit-clear skip skips when selected I/O bit is 0, 2/3/4 cycles.
// - I/O bit-set skip skips when selected I/O bit is 1, 2/3/4 cycles.
// - Flag-set branch goes to PC plus offset plus one when flag is 1.
// - Flag-clear branch goes relative when flag is 0, else sequential.
// - Signed greater-or-equal branch taken when N xor V is 0.
// - Signed less-than branch taken when N xor V is 1.
// - Unsigned same-or-higher taken on carry 0, lower on carry 1.
// - Carry branches test C; equal and not-equal branches test Z.
// - Half-carry and negative branches test H and N for set or clear.
// - Overflow branches test V for set or clear, same relative target.
// - Interrupt-enabled branch tests I at 1, disabled branch at 0.
// - T-flag branches test T; no branch changes any flag.
`timescale 1ns/1ps
`default_nettype none
module bscu_top
  import bscu_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic instr_valid,
  input wire bscu_instr_t instr,
  output logic instr_ready,
  output logic done,
  output bscu_result_t result,
  output logic [7:0] flags_out,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  bscu_state_t state_q, state_d;
  logic [CYC_W-1:0] cnt_q, cnt_d;
  bscu_result_t res_q, res_d;
  bscu_result_t calc;
  logic [7:0] res_flags_q, res_flags_d;
  logic flags_upd_q, flags_upd_d;
  logic ready_q, ready_d;
  logic done_q, done_d;
  logic [7:0] flags_q, flags_d;
  logic [EXT_W-1:0] ext_q, ext_d;
  logic [7:0] ctrl_q, ctrl_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;

  logic [7:0] cmp_flags;
  logic [7:0] bit_byte;
  logic flag_hit, bit_hit;
  logic flag_want, bit_want;
  logic is_io, is_carry_cmp;
  logic [PC_W-1:0] rel_target;
  logic [PC_W-1:0] skip_dist;
  logic [CYC_W-1:0] skip_cyc;
  logic accept, finish;
  logic apb_setup, apb_access, apb_wr;
  logic addr_ok;

  assign flag_want = (instr.op == BSCU_OP_FLAG_SET_BR);
  assign is_io = (instr.op == BSCU_OP_IOBIT_CLR_SKIP) || (instr.op == BSCU_OP_IOBIT_SET_SKIP);
  assign bit_byte = is_io ? instr.io_val : instr.rr_val;
  assign bit_want = (instr.op == BSCU_OP_RBIT_SET_SKIP) || (instr.op == BSCU_OP_IOBIT_SET_SKIP);
  assign is_carry_cmp = (instr.op == BSCU_OP_CMP_CARRY);

  // Named branches arrive as flag-set or flag-clear with a flag selector
  bscu_cond_eval #(
    .NV_SIGN(1'b1)
  ) u_flag_cond (
    .src(flags_q),
    .sel(instr.sel),
    .want(flag_want),
    .hit(flag_hit)
  );

  bscu_cond_eval #(
    .NV_SIGN(1'b0)
  ) u_bit_cond (
    .src(bit_byte),
    .sel(instr.sel),
    .want(bit_want),
    .hit(bit_hit)
  );

  bscu_sub_flags u_sub (
    .a(instr.rd_val),
    .b(instr.rr_val),
    .use_carry(is_carry_cmp),
    .flags_in(flags_q),
    .flags_out(cmp_flags)
  );

  // Relative target: PC plus sign-extended offset plus one
  assign rel_target = instr.pc + {{(PC_W-OFS_W){instr.offset[OFS_W-1]}}, instr.offset} + PC_STEP;
  assign skip_dist = instr.next_two_word ? PC_SKIP_TWO : PC_SKIP_ONE;
  assign skip_cyc = instr.next_two_word ? CYC_SKIP_TWO : CYC_SKIP_ONE;

  always_comb begin
    calc.pc = instr.pc + PC_STEP;
    calc.taken = 1'b0;
    calc.cycles = CYC_CMP;
    res_flags_d = flags_q;
    flags_upd_d = 1'b0;
    unique case (instr.op)
      BSCU_OP_IND_CALL: begin
        calc.pc = {{(PC_W-ZP_W){1'b0}}, instr.z_ptr};
        calc.taken = 1'b1;
        calc.cycles = ctrl_q[CTRL_LONG_CALL_BIT] ? CYC_IND_CALL_LONG : CYC_IND_CALL_SHORT;
      end
      BSCU_OP_EXT_CALL: begin
        calc.pc = {ext_q, instr.z_ptr};
        calc.taken = 1'b1;
        calc.cycles = CYC_EXT_CALL;
      end
      BSCU_OP_CMP_SKIP: begin
        if (instr.rd_val == instr.rr_val) begin
          calc.pc = instr.pc + skip_dist;
          calc.taken = 1'b1;
          calc.cycles = skip_cyc;
        end else begin
          calc.cycles = CYC_SKIP_NONE;
        end
      end
      BSCU_OP_RBIT_CLR_SKIP, BSCU_OP_RBIT_SET_SKIP: begin
        if (bit_hit) begin
          calc.pc = instr.pc + skip_dist;
          calc.taken = 1'b1;
          calc.cycles = skip_cyc;
        end else begin
          calc.cycles = CYC_SKIP_NONE;
        end
      end
      BSCU_OP_IOBIT_CLR_SKIP, BSCU_OP_IOBIT_SET_SKIP: begin
        // I/O read costs one extra cycle on every outcome
        if (bit_hit) begin
          calc.pc = instr.pc + skip_dist;
          calc.taken = 1'b1;
          calc.cycles = skip_cyc + CYC_IO_EXTRA;
        end else begin
          calc.cycles = CYC_SKIP_NONE + CYC_IO_EXTRA;
        end
      end
      BSCU_OP_FLAG_SET_BR, BSCU_OP_FLAG_CLR_BR: begin
        // Flags stay untouched on every branch
        if (flag_hit) begin
          calc.pc = rel_target;
          calc.taken = 1'b1;
          calc.cycles = CYC_BR_TAKEN;
        end else begin
          calc.cycles = CYC_BR_NOT;
        end
      end
      BSCU_OP_CMP, BSCU_OP_CMP_CARRY, BSCU_OP_CMP_IMM: begin
        res_flags_d = cmp_flags;
        flags_upd_d = 1'b1;
      end
      default: begin
        calc.cycles = CYC_CMP;
      end
    endcase
  end

  assign accept = (state_q == BSCU_IDLE) && instr_valid;
  assign finish = (state_q == BSCU_RUN) && (cnt_q == 3'h1);

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    res_d = res_q;
    ready_d = ready_q;
    done_d = 1'b0;
    unique case (state_q)
      BSCU_IDLE: begin
        if (instr_valid) begin
          state_d = BSCU_RUN;
          cnt_d = calc.cycles;
          res_d = calc;
          ready_d = 1'b0;
        end
      end
      BSCU_RUN: begin
        cnt_d = cnt_q - 3'h1;
        if (cnt_q == 3'h1) begin
          state_d = BSCU_IDLE;
          ready_d = 1'b1;
          done_d = 1'b1;
        end
      end
    endcase
  end

  assign apb_setup = psel && !penable;
  assign apb_access = psel && penable && pready_q;
  assign apb_wr = apb_access && pwrite && !pslverr_q;
  assign addr_ok = (paddr == REG_FLAGS_OFS) || (paddr == REG_EXT_OFS) ||
                   (paddr == REG_CTRL_OFS) || (paddr == REG_STAT_OFS);

  always_comb begin
    flags_d = flags_q;
    ext_d = ext_q;
    ctrl_d = ctrl_q;
    prdata_d = prdata_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    if (apb_setup && !pready_q) begin
      // Answer is prepared in setup so the access phase lasts one cycle
      pready_d = 1'b1;
      pslverr_d = !addr_ok;
      prdata_d = 32'h00000000;
      if (!pwrite) begin
        unique case (paddr)
          REG_FLAGS_OFS: prdata_d = {24'h000000, flags_q};
          REG_EXT_OFS: prdata_d = {26'h0000000, ext_q};
          REG_CTRL_OFS: prdata_d = {24'h000000, ctrl_q};
          REG_STAT_OFS: begin
            prdata_d[STAT_BUSY_BIT] = !ready_q;
            prdata_d[STAT_TAKEN_BIT] = result.taken;
            prdata_d[STAT_CYC_LSB +: CYC_W] = result.cycles;
          end
          default: prdata_d = 32'h00000000;
        endcase
      end
    end
    if (apb_wr) begin
      unique case (paddr)
        REG_FLAGS_OFS: flags_d = pwdata[7:0];
        REG_EXT_OFS: ext_d = pwdata[EXT_W-1:0];
        REG_CTRL_OFS: ctrl_d = pwdata[7:0];
        default: ctrl_d = ctrl_q;
      endcase
    end
    // Compare result beats a software write landing in the same cycle
    if (finish && flags_upd_q) begin
      flags_d = res_flags_q;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= BSCU_IDLE;
      cnt_q <= 3'h0;
      res_q <= '0;
      res_flags_q <= FLAGS_RST;
      flags_upd_q <= 1'b0;
      ready_q <= 1'b1;
      done_q <= 1'b0;
      flags_q <= FLAGS_RST;
      ext_q <= EXT_RST;
      ctrl_q <= CTRL_RST;
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      res_q <= res_d;
      if (accept) begin
        res_flags_q <= res_flags_d;
        flags_upd_q <= flags_upd_d;
      end
      ready_q <= ready_d;
      done_q <= done_d;
      flags_q <= flags_d;
      ext_q <= ext_d;
      ctrl_q <= ctrl_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Result register only follows a finished operation
  bscu_result_t result_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result_q <= '0;
    end else if (finish) begin
      result_q <= res_q;
    end
  end

  assign instr_ready = ready_q;
  assign done = done_q;
  assign result = result_q;
  assign flags_out = flags_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
endmodule
`default_nettype wire

// *** rtl/bscu_pkg.sv ***
// Shared constants and types for the branch, skip and call unit.
// Assumes a core decoder that delivers pre-decoded operations and operands.
package bscu_pkg;
  localparam int PC_W = 22;
  localparam int ZP_W = 16;
  localparam int EXT_W = 6;
  localparam int OFS_W = 7;
  localparam int CYC_W = 3;
  localparam int ADDR_W = 8;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] REG_FLAGS_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] REG_EXT_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_CTRL_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] REG_STAT_OFS = 8'h0C;

  // Reset values
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [EXT_W-1:0] EXT_RST = 6'h00;
  localparam logic [7:0] CTRL_RST = 8'h01;

  // Field positions
  localparam int CTRL_LONG_CALL_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_TAKEN_BIT = 1;
  localparam int STAT_CYC_LSB = 2;

  // Flag register bit positions
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;

  // Cycle counts
  localparam logic [CYC_W-1:0] CYC_CMP = 3'h1;
  localparam logic [CYC_W-1:0] CYC_BR_NOT = 3'h1;
  localparam logic [CYC_W-1:0] CYC_BR_TAKEN = 3'h2;
  localparam logic [CYC_W-1:0] CYC_SKIP_NONE = 3'h1;
  localparam logic [CYC_W-1:0] CYC_SKIP_ONE = 3'h2;
  localparam logic [CYC_W-1:0] CYC_SKIP_TWO = 3'h3;
  localparam logic [CYC_W-1:0] CYC_IO_EXTRA = 3'h1;
  localparam logic [CYC_W-1:0] CYC_IND_CALL_SHORT = 3'h2;
  localparam logic [CYC_W-1:0] CYC_IND_CALL_LONG = 3'h3;
  localparam logic [CYC_W-1:0] CYC_EXT_CALL = 3'h3;

  // Program counter steps
  localparam logic [PC_W-1:0] PC_STEP = 22'h000001;
  localparam logic [PC_W-1:0] PC_SKIP_ONE = 22'h000002;
  localparam logic [PC_W-1:0] PC_SKIP_TWO = 22'h000003;

  typedef enum logic [3:0] {
    BSCU_OP_NONE = 4'h0,
    BSCU_OP_IND_CALL = 4'h1,
    BSCU_OP_EXT_CALL = 4'h2,
    BSCU_OP_CMP_SKIP = 4'h3,
    BSCU_OP_RBIT_CLR_SKIP = 4'h4,
    BSCU_OP_RBIT_SET_SKIP = 4'h5,
    BSCU_OP_IOBIT_CLR_SKIP = 4'h6,
    BSCU_OP_IOBIT_SET_SKIP = 4'h7,
    BSCU_OP_FLAG_SET_BR = 4'h8,
    BSCU_OP_FLAG_CLR_BR = 4'h9,
    BSCU_OP_CMP = 4'hA,
    BSCU_OP_CMP_CARRY = 4'hB,
    BSCU_OP_CMP_IMM = 4'hC
  } bscu_op_t;

  typedef struct packed {
    bscu_op_t op;
    logic [2:0] sel;
    logic [OFS_W-1:0] offset;
    logic [PC_W-1:0] pc;
    logic [ZP_W-1:0] z_ptr;
    logic [7:0] rd_val;
    logic [7:0] rr_val;
    logic [7:0] io_val;
    logic next_two_word;
  } bscu_instr_t;

  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic taken;
    logic [CYC_W-1:0] cycles;
  } bscu_result_t;

  typedef enum logic {
    BSCU_IDLE = 1'b0,
    BSCU_RUN = 1'b1
  } bscu_state_t;
endpackage

// *** rtl/bscu_cond_eval.sv ***
// Picks one bit of a byte and compares it with the wanted level.
// Assumes same-clock combinational inputs.
`timescale 1ns/1ps
`default_nettype none
module bscu_cond_eval
  import bscu_pkg::*;
#(
  parameter bit NV_SIGN = 1'b0
) (
  input wire logic [7:0] src,
  input wire logic [2:0] sel,
  input wire logic want,
  output logic hit
);
  logic bit_val;

  always_comb begin
    // Signed test from live N and V, not a stale stored S
    if (NV_SIGN && (sel == FLAG_S)) begin
      bit_val = src[FLAG_N] ^ src[FLAG_V];
    end else begin
      bit_val = src[sel];
    end
    hit = (bit_val == want);
  end
endmodule
`default_nettype wire

// *** rtl/bscu_sub_flags.sv ***
// Flag results of an 8-bit subtraction used by the compare operations.
// Assumes same-clock combinational inputs; T and I pass through.
`timescale 1ns/1ps
`default_nettype none
module bscu_sub_flags
  import bscu_pkg::*;
(
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic use_carry,
  input wire logic [7:0] flags_in,
  output logic [7:0] flags_out
);
  logic [7:0] r;
  logic cin;

  always_comb begin
    cin = use_carry & flags_in[FLAG_C];
    r = a - b - {7'h00, cin};
    flags_out = flags_in;
    flags_out[FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
    flags_out[FLAG_C] = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
    flags_out[FLAG_N] = r[7];
    flags_out[FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    flags_out[FLAG_S] = r[7] ^ flags_out[FLAG_V];
    // Carry form keeps Z only while the whole chain is zero
    if (use_carry) begin
      flags_out[FLAG_Z] = (r == 8'h00) & flags_in[FLAG_Z];
    end else begin
      flags_out[FLAG_Z] = (r == 8'h00);
    end
  end
endmodule
`default_nettype wire

// *** tb/bscu_checker.sv ***
// Port timing checks for the branch, skip and call unit.
// Assumes bind onto bscu_top; one clock, async active-high reset.
`timescale 1ns/1ps
`default_nettype none
module bscu_checker
  import bscu_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic instr_valid,
  input wire bscu_instr_t instr,
  input wire logic instr_ready,
  input wire logic done,
  input wire bscu_result_t result,
  input wire logic [7:0] flags_out,
  input wire logic psel,
  input wire logic penable,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic acc;
  assign acc = instr_valid && instr_ready;

  a_done_pulse: assert property (done |=> !done)
    else $error("done high for more than one cycle");
  a_busy_accept: assert property (acc |=> !instr_ready)
    else $error("ready stayed high after accept");
  a_ext_call: assert property (acc && instr.op == BSCU_OP_EXT_CALL |=> !done [*3] ##1
    (done && result.cycles == CYC_EXT_CALL && result.pc[15:0] == $past(instr.z_ptr, 4)))
    else $error("extended call target or timing wrong");
  a_call_upper: assert property (acc && instr.op == BSCU_OP_IND_CALL |-> ##[3:4]
    (done && result.pc[PC_W-1:ZP_W] == 6'h00))
    else $error("indirect call upper bits not zero");
  a_branch_taken: assert property (acc && instr.op == BSCU_OP_FLAG_SET_BR && instr.sel != 3'h4
    && flags_out[instr.sel] |=> !done [*2] ##1 (done && result.taken && result.pc ==
    $past(instr.pc, 3) + {{15{$past(instr.offset[6], 3)}}, $past(instr.offset, 3)} + PC_STEP))
    else $error("taken branch target or timing wrong");
  a_branch_seq: assert property (acc && instr.op == BSCU_OP_FLAG_CLR_BR && instr.sel != 3'h4
    && flags_out[instr.sel] |=> !done ##1 (done && !result.taken && result.pc == $past(instr.pc, 2) + PC_STEP))
    else $error("untaken branch not sequential");
  a_io_skip_far: assert property (acc && instr.op == BSCU_OP_IOBIT_SET_SKIP && instr.next_two_word
    && instr.io_val[instr.sel] |=> !done [*4] ##1 (done && result.pc == $past(instr.pc, 5) + PC_SKIP_TWO))
    else $error("io skip over two words wrong");
  a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("apb ready not one cycle after setup");
  a_apb_err: assert property (psel && !penable && paddr > REG_STAT_OFS |=> pslverr)
    else $error("unmapped address without error");
endmodule

bind bscu_top bscu_checker i_chk (.clk(clk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
  .instr_ready(instr_ready), .done(done), .result(result), .flags_out(flags_out), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for bscu_top: APB and instruction tasks.
// Assumes the unit answers per its hand-over timing; no partner model.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import bscu_pkg::*;
  localparam logic [7:0] V = 8'hA5;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic instr_valid = 1'b0;
  bscu_instr_t instr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic instr_ready, done, pready, pslverr;
  bscu_result_t result;
  logic [7:0] flags_out;
  logic [31:0] prdata;
  int failures = 0;
  int n_tests = 0;

  bscu_top i_dut (.clk(clk), .rst(rst), .instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready),
    .done(done), .result(result), .flags_out(flags_out), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  always #25 clk = ~clk;

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Entered just after a rising edge; leaves one idle cycle so psel is never set twice at once
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 20) begin
      failures++;
      finish_test();
    end
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    check(q, x);
    check(e, xe);
  endtask

  // Fixed pc 0x1000 and Z 0xBEEF keep the argument list short
  task automatic op(input bscu_op_t o, input logic [2:0] s, input logic [6:0] f, input logic [7:0] d,
                    input logic [7:0] r, input logic two, input logic [21:0] xpc, input logic xt,
                    input logic [2:0] xc);
    int k;
    instr <= '{o, s, f, 22'h001000, 16'hBEEF, d, r, r, two};
    instr_valid <= 1'b1;
    @(posedge clk);
    instr_valid <= 1'b0;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (done !== 1'b1 && k < 8);
    if (k == 8) begin
      failures++;
      finish_test();
    end
    check(32'(k), 32'(xc) + 32'h1);
    check(result.pc, xpc);
    check(result.taken, xt);
    check(result.cycles, xc);
  endtask

  task automatic skip(input bscu_op_t o, input int s, input logic t, input logic [2:0] x);
    op(o, s[2:0], 7'h00, 8'h00, V, s[0], t ? 22'h001002 + s[0] : 22'h001001, t, x + (t ? 3'h1 + s[0] : 3'h0));
  endtask

  // Odd selects use a backward offset so sign extension is exercised
  task automatic br(input bscu_op_t o, input int s, input logic t);
    logic [6:0] f;
    f = s[0] ? 7'h7C : 7'h10;
    op(o, s[2:0], f, 8'h00, 8'h00, 1'b0, t ? 22'h001001 + {{15{f[6]}}, f} : 22'h001001, t, t ? 3'h2 : 3'h1);
  endtask

  initial begin
    logic [7:0] fl [3];
    logic t;
    fl = '{8'h5A, 8'h33, 8'hA5};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(REG_FLAGS_OFS, 32'h0, 1'b0);
    rd(REG_EXT_OFS, 32'h0, 1'b0);
    rd(REG_CTRL_OFS, 32'h1, 1'b0);
    rd(8'h10, 32'h0, 1'b1);
    $display("test registers done");
    wr(REG_EXT_OFS, 32'h2A);
    op(BSCU_OP_EXT_CALL, 3'h0, 7'h00, 8'h00, 8'h00, 1'b0, {6'h2A, 16'hBEEF}, 1'b1, 3'h3);
    op(BSCU_OP_IND_CALL, 3'h0, 7'h00, 8'h00, 8'h00, 1'b0, {6'h00, 16'hBEEF}, 1'b1, 3'h3);
    wr(REG_CTRL_OFS, 32'h0);
    op(BSCU_OP_IND_CALL, 3'h0, 7'h00, 8'h00, 8'h00, 1'b0, {6'h00, 16'hBEEF}, 1'b1, 3'h2);
    $display("test calls done");
    op(BSCU_OP_CMP_SKIP, 3'h0, 7'h00, 8'h55, 8'h55, 1'b1, 22'h001003, 1'b1, 3'h3);
    op(BSCU_OP_CMP_SKIP, 3'h0, 7'h00, 8'h55, 8'h55, 1'b0, 22'h001002, 1'b1, 3'h2);
    op(BSCU_OP_CMP_SKIP, 3'h0, 7'h00, 8'h55, 8'h54, 1'b1, 22'h001001, 1'b0, 3'h1);
    for (int s = 0; s < 8; s++) begin
      skip(BSCU_OP_RBIT_CLR_SKIP, s, !V[s], 3'h1);
      skip(BSCU_OP_RBIT_SET_SKIP, s, V[s], 3'h1);
      skip(BSCU_OP_IOBIT_CLR_SKIP, s, !V[s], 3'h2);
      skip(BSCU_OP_IOBIT_SET_SKIP, s, V[s], 3'h2);
    end
    $display("test skips done");
    for (int i = 0; i < 3; i++) begin
      wr(REG_FLAGS_OFS, {24'h0, fl[i]});
      for (int s = 0; s < 8; s++) begin
        t = (s == 4) ? fl[i][2] ^ fl[i][3] : fl[i][s];
        br(BSCU_OP_FLAG_SET_BR, s, t);
        br(BSCU_OP_FLAG_CLR_BR, s, !t);
      end
      check(flags_out, fl[i]);
    end
    $display("test branches done");
    wr(REG_FLAGS_OFS, 32'hC0);
    op(BSCU_OP_CMP, 3'h0, 7'h00, 8'h10, 8'h20, 1'b0, 22'h001001, 1'b0, 3'h1);
    check(flags_out, 8'hD5);
    wr(REG_FLAGS_OFS, 32'h03);
    op(BSCU_OP_CMP_CARRY, 3'h0, 7'h00, 8'h20, 8'h1F, 1'b0, 22'h001001, 1'b0, 3'h1);
    check(flags_out, 8'h22);
    op(BSCU_OP_CMP_IMM, 3'h0, 7'h00, 8'h80, 8'h01, 1'b0, 22'h001001, 1'b0, 3'h1);
    rd(REG_FLAGS_OFS, 32'h38, 1'b0);
    rd(REG_STAT_OFS, 32'h4, 1'b0);
    $display("test compares done");
    finish_test();
  end
endmodule
`default_nettype wire
